// ---- sbat_pkg.sv ----
`default_nettype none
package sbat_pkg;
  // register map, word aligned
  localparam logic [11:0] SBAT_OFS_CTRL = 12'h000;
  localparam logic [11:0] SBAT_OFS_COUNT_LOW = 12'h004;
  localparam logic [11:0] SBAT_OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] SBAT_OFS_IRQ_MASK = 12'h00C;

  // arbiter_control_status field positions
  localparam int SBAT_BIT_MODE_HIGH = 7;
  localparam int SBAT_BIT_MODE_LOW = 6;
  localparam int SBAT_BIT_LOST = 5;
  localparam int SBAT_BIT_ACLK = 4;
  localparam int SBAT_BIT_DONE = 3;
  localparam int SBAT_BIT_RUN = 2;
  localparam int SBAT_BIT_OVFL = 1;
  localparam int SBAT_BIT_MSB = 0;

  // interrupt status and mask layout
  localparam int SBAT_IRQ_DONE = 0;
  localparam int SBAT_IRQ_LOST = 1;
  localparam int SBAT_IRQ_OVFL = 2;
  localparam int SBAT_IRQ_WIDTH = 3;

  // counter geometry and arbitration sample points
  localparam int SBAT_COUNT_WIDTH = 9;
  localparam logic [8:0] SBAT_SAMPLE_BUS = 9'h038;
  localparam logic [8:0] SBAT_SAMPLE_PRESCALE = 9'h008;
  localparam logic [8:0] SBAT_COUNT_ZERO = 9'h000;
  localparam logic [9:0] SBAT_COUNT_ONE = 10'h001;

  // bus clock divider for the quarter-rate tick
  localparam int SBAT_BUS_DIV = 4;

  // reset values
  localparam logic [31:0] SBAT_DATA_ZERO = 32'h0000_0000;
  localparam logic [2:0] SBAT_IRQ_ZERO = 3'h0;

  typedef enum logic [1:0] {
    SBAT_MODE_IDLE = 2'h0,
    SBAT_MODE_MEASURE = 2'h1,
    SBAT_MODE_ARB = 2'h2,
    SBAT_MODE_RSVD = 2'h3
  } sbat_mode_type;

  // software-written control fields
  typedef struct packed {
    sbat_mode_type mode;
    logic aclk;
  } sbat_ctrl_type;

  localparam sbat_ctrl_type SBAT_CTRL_RESET = '{mode: SBAT_MODE_IDLE, aclk: 1'b0};
endpackage
`default_nettype wire

// ---- sbat_top.sv ----
// Operation
// RULE1 - nine-bit counter with overflow bit and control
// RULE2 - mode field: idle, measure, arbitrate, reserved
// RULE3 - mode bits read/write, reset clears them
// RULE4 - lost flag read-only, cleared by mode-high zero
// RULE5 - clock select: quarter bus or half prescale
// RULE6 - done flag set on finish, cleared by write
// RULE7 - running flag shows counter counting
// RULE8 - overflow flag set on wrap, cleared by write
// RULE9 - idle mode holds counter at zero
// RULE10 - count readable in two registers, write clears
// RULE11 - bus clock: falling edge to falling edge
// RULE12 - prescale clock: low level to rising edge
// RULE13 - arbitration restarts counter on transmit rise
// RULE14 - sample receive at fixed count, low loses
// RULE15 - lost forces transmit pin high
// RULE16 - transmit low without receive low resets counter
// RULE17 - winning node drives line low at sample
// RULE18 - overflow at wrap past 511 stays sticky
`default_nettype none
module sbat_top
  import sbat_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int BUS_DIV = SBAT_BUS_DIV
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial core side
  input wire logic serial_core_tx_internal_i,
  input wire logic prescale_tick_i,
  // line pins
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  // interrupt
  output logic irq_o
);

  // refuse geometries the decode and divider cannot serve
  initial begin
    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 12) begin
      $error("sbat_top: ADDR_WIDTH must be 4..12");
    end
    if (BUS_DIV != SBAT_BUS_DIV) begin
      $error("sbat_top: BUS_DIV must stay at the quarter rate");
    end
  end

  typedef enum {MS_WAIT, MS_RUN, MS_DONE} sbat_ms_type;

  sbat_ctrl_type ctrl_reg;
  sbat_ms_type ms_reg, ms_next;
  logic [8:0] count_reg, count_next;
  logic run_reg, run_next;
  logic lost_reg, done_reg, ovfl_reg;
  logic sampled_reg, sampled_next;
  logic rxlow_reg, rxlow_next;
  logic ovfl_set, done_set, lost_set;
  logic [1:0] div_reg;
  logic half_reg;
  logic rx_s1_reg, rx_s2_reg, rx_d_reg;
  logic tx_d_reg;
  logic tx_pin_reg;
  logic [SBAT_IRQ_WIDTH-1:0] irq_status_reg, irq_mask_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  // apb decode; one wait state so read data can come from a flop
  wire [11:0] addr_w = 12'(paddr_i);
  wire apb_access = psel_i && penable_i;
  wire apb_done = apb_access && pready_reg;
  wire sel_ctrl = (addr_w == SBAT_OFS_CTRL);
  wire sel_count = (addr_w == SBAT_OFS_COUNT_LOW);
  wire sel_status = (addr_w == SBAT_OFS_IRQ_STATUS);
  wire sel_mask = (addr_w == SBAT_OFS_IRQ_MASK);
  wire sel_any = sel_ctrl || sel_count || sel_status || sel_mask;
  wire wr_done = apb_done && pwrite_i;
  wire wr_ctrl = wr_done && sel_ctrl;
  wire wr_status = wr_done && sel_status;
  wire wr_mask = wr_done && sel_mask;
  wire lost_clear = wr_ctrl && !pwdata_i[SBAT_BIT_MODE_HIGH];

  // read views
  wire [7:0] ctrl_view = {ctrl_reg.mode, lost_reg, ctrl_reg.aclk, done_reg, run_reg, ovfl_reg,
                          count_reg[8]};
  wire [31:0] rdata_w = sel_ctrl ? {24'h00_0000, ctrl_view} :
                        sel_count ? {24'h00_0000, count_reg[7:0]} :
                        sel_status ? {29'h0000_0000, irq_status_reg} :
                        sel_mask ? {29'h0000_0000, irq_mask_reg} : SBAT_DATA_ZERO;

  // line conditioning; receive edges compare the second and third stage only
  wire rx_w = rx_s2_reg;
  wire rx_fall = rx_d_reg && !rx_s2_reg;
  wire rx_rise = !rx_d_reg && rx_s2_reg;
  wire tx_rise = serial_core_tx_internal_i && !tx_d_reg;
  wire tx_fall = !serial_core_tx_internal_i && tx_d_reg;

  // counter tick from the selected source
  wire bus_tick = (div_reg == 2'(BUS_DIV - 1));
  wire pre_tick = prescale_tick_i && half_reg;
  wire tick = ctrl_reg.aclk ? pre_tick : bus_tick; // [RULE5]
  wire [8:0] sample_w = ctrl_reg.aclk ? SBAT_SAMPLE_PRESCALE : SBAT_SAMPLE_BUS;
  wire [9:0] count_inc = {1'b0, count_reg} + SBAT_COUNT_ONE;
  // lows count only once the count is past one: our own echoed transmit low
  // lingers in the synchroniser just after a restart; a real low that early is missed
  wire echo_clear = ({1'b0, count_reg} > SBAT_COUNT_ONE);
  wire [SBAT_IRQ_WIDTH-1:0] irq_events = {ovfl_set, lost_set, done_set};

  // synchroniser and edge history
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_d_reg <= 1'b1;
      tx_d_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_pin_i;
      rx_s2_reg <= rx_s1_reg;
      rx_d_reg <= rx_s2_reg;
      tx_d_reg <= serial_core_tx_internal_i;
    end
  end

  // dividers: free-running quarter of bus, halved prescaler ticks
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_reg <= 2'h0;
      half_reg <= 1'b0;
    end else begin
      div_reg <= bus_tick ? 2'h0 : div_reg + 2'h1; // [RULE5]
      if (prescale_tick_i) begin
        half_reg <= !half_reg; // [RULE5]
      end
    end
  end

  // counter and function control
  always_comb begin
    count_next = count_reg;
    run_next = run_reg;
    ms_next = ms_reg;
    sampled_next = sampled_reg;
    rxlow_next = rxlow_reg;
    ovfl_set = 1'b0;
    done_set = 1'b0;
    lost_set = 1'b0;
    if (run_reg && tick) begin
      count_next = count_inc[8:0]; // [RULE1]
      ovfl_set = count_inc[9]; // [RULE18]
    end
    unique case (ctrl_reg.mode) // [RULE2]
      SBAT_MODE_MEASURE: begin
        unique case (ms_reg)
          MS_WAIT: begin
            // prescale clock starts on level, so an already low line starts at once
            if (ctrl_reg.aclk ? !rx_w : rx_fall) begin // [RULE11] [RULE12]
              count_next = SBAT_COUNT_ZERO;
              run_next = 1'b1;
              ms_next = MS_RUN;
            end
          end
          MS_RUN: begin
            if (ctrl_reg.aclk ? rx_rise : rx_fall) begin // [RULE11] [RULE12]
              count_next = count_reg;
              ovfl_set = 1'b0;
              run_next = 1'b0;
              done_set = 1'b1; // [RULE6]
              ms_next = MS_DONE;
            end
          end
          MS_DONE: begin
            run_next = 1'b0;
          end
        endcase
      end
      SBAT_MODE_ARB: begin
        ms_next = MS_WAIT;
        if (tx_rise) begin
          count_next = SBAT_COUNT_ZERO; // [RULE13]
          run_next = 1'b1;
          sampled_next = 1'b0;
          rxlow_next = 1'b0;
        end else if (tx_fall && !rxlow_reg) begin
          count_next = SBAT_COUNT_ZERO; // [RULE16]
          run_next = 1'b0;
        end else begin
          if (run_reg && !rx_w && echo_clear) begin
            rxlow_next = 1'b1; // [RULE16]
          end
          // one static look at the line per restart
          if (run_reg && !sampled_reg && count_reg == sample_w) begin
            sampled_next = 1'b1;
            lost_set = !rx_w; // [RULE14] [RULE17]
          end
        end
      end
      default: begin
        // idle, and the reserved code treated alike
        count_next = SBAT_COUNT_ZERO; // [RULE9]
        run_next = 1'b0;
        ms_next = MS_WAIT;
        sampled_next = 1'b1;
      end
    endcase
    // any control write clears the count and rearms measurement
    if (wr_ctrl) begin
      count_next = SBAT_COUNT_ZERO; // [RULE10]
      run_next = 1'b0;
      ms_next = MS_WAIT;
      sampled_next = 1'b1;
      ovfl_set = 1'b0;
    end
  end

  // counter state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= SBAT_COUNT_ZERO;
      run_reg <= 1'b0;
      ms_reg <= MS_WAIT;
      sampled_reg <= 1'b1;
      rxlow_reg <= 1'b0;
    end else begin
      count_reg <= count_next; // [RULE1]
      run_reg <= run_next; // [RULE7]
      ms_reg <= ms_next;
      sampled_reg <= sampled_next;
      rxlow_reg <= rxlow_next;
    end
  end

  // control fields written by software
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= SBAT_CTRL_RESET; // [RULE3]
    end else if (wr_ctrl) begin
      ctrl_reg.mode <= sbat_mode_type'(pwdata_i[SBAT_BIT_MODE_HIGH:SBAT_BIT_MODE_LOW]); // [RULE3]
      ctrl_reg.aclk <= pwdata_i[SBAT_BIT_ACLK];
    end
  end

  // status flags; a lost or done set in the same cycle beats the clear, but a control write cancels an overflow set
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lost_reg <= 1'b0;
      done_reg <= 1'b0;
      ovfl_reg <= 1'b0;
    end else begin
      if (lost_set) begin
        lost_reg <= 1'b1; // [RULE14]
      end else if (lost_clear) begin
        lost_reg <= 1'b0; // [RULE4]
      end
      if (done_set) begin
        done_reg <= 1'b1; // [RULE6]
      end else if (wr_ctrl) begin
        done_reg <= 1'b0; // [RULE6]
      end
      if (ovfl_set) begin
        ovfl_reg <= 1'b1; // [RULE8] [RULE18]
      end else if (wr_ctrl) begin
        ovfl_reg <= 1'b0; // [RULE8]
      end
    end
  end

  // transmit pin; held high while arbitration is lost
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_pin_reg <= 1'b1;
    end else begin
      tx_pin_reg <= lost_reg || serial_core_tx_internal_i; // [RULE15]
    end
  end

  // interrupt status, write one to clear, events win
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status_reg <= SBAT_IRQ_ZERO;
      irq_mask_reg <= SBAT_IRQ_ZERO;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_events | (irq_status_reg & ~(wr_status ? pwdata_i[2:0] : SBAT_IRQ_ZERO));
      if (wr_mask) begin
        irq_mask_reg <= pwdata_i[2:0];
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // apb answer: ready one cycle into the access phase
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= SBAT_DATA_ZERO;
    end else begin
      pready_reg <= apb_access && !pready_reg;
      pslverr_reg <= apb_access && !pready_reg && !sel_any;
      prdata_reg <= (apb_access && !pready_reg && !pwrite_i) ? rdata_w : SBAT_DATA_ZERO;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign tx_pin_o = tx_pin_reg;
  assign irq_o = irq_reg;

  // checks on the block's own behaviour
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  idle_hold_a: assert property ((ctrl_reg.mode == SBAT_MODE_IDLE) // [RULE9]
    |=> (count_reg == SBAT_COUNT_ZERO) && !run_reg)
    else $error("counter not held in idle");

  lost_sticky_a: assert property ((lost_reg && !lost_clear) |=> lost_reg) // [RULE4]
    else $error("lost flag dropped without clear");

  tx_forced_a: assert property (lost_reg |=> tx_pin_o) // [RULE15]
    else $error("transmit pin not forced high");

  done_clear_a: assert property ((wr_ctrl && !done_set) |=> !done_reg ##1 (done_reg == $past(done_set))) // [RULE6]
    else $error("done flag not cleared by write");

  ovfl_wrap_a: assert property ((run_reg && tick && count_reg == 9'h1FF && !wr_ctrl && !done_set) // [RULE18]
    |=> ovfl_reg && count_reg == SBAT_COUNT_ZERO)
    else $error("overflow not flagged at wrap");

  count_clear_a: assert property (wr_ctrl |=> (count_reg == SBAT_COUNT_ZERO) && !ovfl_reg) // [RULE10]
    else $error("control write did not clear count");

  done_stops_a: assert property ((done_set && !wr_ctrl) |=> !run_reg && done_reg && $stable(count_reg)) // [RULE7]
    else $error("counter still running after finish");

  arb_restart_a: assert property ((ctrl_reg.mode == SBAT_MODE_ARB && tx_rise && !wr_ctrl) // [RULE13]
    |=> run_reg && count_reg == SBAT_COUNT_ZERO)
    else $error("arbitration did not restart counter");

  arb_drop_a: assert property ((ctrl_reg.mode == SBAT_MODE_ARB && tx_fall && !rxlow_reg && !wr_ctrl) // [RULE16]
    |=> !run_reg && count_reg == SBAT_COUNT_ZERO)
    else $error("transmit drop did not reset counter");

  lost_point_a: assert property (lost_set // [RULE14]
    |-> (count_reg == sample_w) && !rx_w && ctrl_reg.mode == SBAT_MODE_ARB)
    else $error("lost set away from sample point");

  tx_follow_a: assert property (!lost_reg |=> tx_pin_o == $past(serial_core_tx_internal_i)) // [RULE15]
    else $error("transmit pin not following core");

  quarter_rate_a: assert property ((!ctrl_reg.aclk && tick) |=> !bus_tick [*3] ##1 bus_tick) // [RULE5]
    else $error("bus tick not one in four");

  bus_start_a: assert property ((ctrl_reg.mode == SBAT_MODE_MEASURE && ms_reg == MS_WAIT && !ctrl_reg.aclk // [RULE11]
    && rx_fall && !wr_ctrl) |=> run_reg)
    else $error("measurement did not start on falling edge");

  bus_stop_a: assert property ((ctrl_reg.mode == SBAT_MODE_MEASURE && ms_reg == MS_RUN && !ctrl_reg.aclk // [RULE11]
    && rx_fall && !wr_ctrl) |=> !run_reg && done_reg)
    else $error("measurement did not stop on falling edge");

  level_start_a: assert property ((ctrl_reg.mode == SBAT_MODE_MEASURE && ms_reg == MS_WAIT && ctrl_reg.aclk // [RULE12]
    && !rx_w && !wr_ctrl) |=> run_reg)
    else $error("measurement did not start on low level");

  level_stop_a: assert property ((ctrl_reg.mode == SBAT_MODE_MEASURE && ms_reg == MS_RUN && ctrl_reg.aclk // [RULE12]
    && rx_rise && !wr_ctrl) |=> !run_reg && done_reg)
    else $error("measurement did not stop on rising edge");

  irq_level_a: assert property (|(irq_status_reg & irq_mask_reg) |=> irq_o)
    else $error("interrupt not raised for unmasked status");

endmodule
`default_nettype wire

// ---- sbat_bus_node.sv ----
`default_nettype none
// another node on the shared single-wire bus: wired-and, so low is dominant
module sbat_bus_node (
  // line side
  input wire logic tx_pin_i,
  input wire logic pull_low_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a node that wants to win pulls the line low across the sample point
  assign line_o = tx_pin_i & ~pull_low_i;
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
  import sbat_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] m; logic [31:0] lo; logic [31:0] hi; logic err;} sbat_tb_note_type;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rx, tx_pin, irq;
  logic tx_int = 1'b1;
  logic presc = 1'b0;
  logic pull = 1'b0;
  logic [31:0] seed = 32'h0000_3D22;
  logic [31:0] v;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int pdiv = 0;
  int n, t0;
  sbat_tb_note_type notes[$];
  sbat_tb_note_type e;

  always #10 ref_clk = ~ref_clk;

  // prescaler stand-in: pulse every third clock so its rate differs from bus/4
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pdiv <= (pdiv == 2) ? 0 : pdiv + 1;
    presc <= (pdiv == 2);
  end

  sbat_top dut (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .serial_core_tx_internal_i(tx_int),
    .prescale_tick_i(presc), .rx_pin_i(rx), .tx_pin_o(tx_pin), .irq_o(irq)
  );

  sbat_bus_node node (.tx_pin_i(tx_pin), .pull_low_i(pull), .line_o(rx));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // note the expected masked window, then read
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] lo, input logic [31:0] hi);
    notes.push_back('{m, lo, hi, a > SBAT_OFS_IRQ_MASK});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cy(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // monitor: pairs each completed read with the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      e = notes.pop_front();
      v = prdata & e.m;
      check((v >= e.lo && v <= e.hi) ? e.lo : v, e.lo);
      check({31'h0, pslverr}, {31'h0, e.err});
    end
  end

  // a hang ends the run through the same closing task
  initial begin
    #400000;
    mismatches++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    stop_test();
  end

  initial begin
    cy(8);
    check({30'h0, tx_pin, irq}, 32'h2);
    rst_b <= 1'b1;
    for (int a = 0; a < 5; a++) rd(12'(a * 4), 32'hFFFF_FFFF, 0, 0);
    apb(1'b1, SBAT_OFS_IRQ_MASK, 32'h0000_0007);
    rd(SBAT_OFS_IRQ_MASK, 32'hFF, 7, 7);
    $display("test reset finished");
    // falling edge to falling edge on the bus-quarter clock
    n = 60 + int'(xs() & 32'h3F);
    apb(1'b1, SBAT_OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0040);
    pull <= 1'b1;
    t0 = cyc;
    cy(8);
    pull <= 1'b0;
    rd(SBAT_OFS_CTRL, 32'h04, 32'h04, 32'h04);
    while (cyc - t0 < n) @(posedge ref_clk);
    pull <= 1'b1;
    cy(10);
    rd(SBAT_OFS_CTRL, 32'hFF, 32'h48, 32'h48);
    rd(SBAT_OFS_COUNT_LOW, 32'hFF, n / 4 - 2, n / 4 + 2);
    rd(SBAT_OFS_IRQ_STATUS, 32'h7, 1, 1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, SBAT_OFS_IRQ_STATUS, 32'h0000_0001);
    cy(3);
    check({31'h0, irq}, 32'h0);
    pull <= 1'b0;
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0040);
    rd(SBAT_OFS_CTRL, 32'hFF, 32'h40, 32'h40);
    rd(SBAT_OFS_COUNT_LOW, 32'hFF, 0, 0);
    $display("test measure_bus finished");
    // low level to rising edge on the prescaler clock, line already low
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0000);
    pull <= 1'b1;
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0050);
    t0 = cyc;
    while (cyc - t0 < n) @(posedge ref_clk);
    pull <= 1'b0;
    cy(10);
    rd(SBAT_OFS_CTRL, 32'hDC, 32'h58, 32'h58);
    rd(SBAT_OFS_COUNT_LOW, 32'hFF, n / 6 - 2, n / 6 + 2);
    $display("test measure_prescale finished");
    // arbitration lost: the other node holds the line low over count 0x38
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0080);
    tx_int <= 1'b0;
    cy(4);
    tx_int <= 1'b1;
    cy(150);
    pull <= 1'b1;
    cy(150);
    pull <= 1'b0;
    rd(SBAT_OFS_CTRL, 32'hE0, 32'hA0, 32'hA0);
    tx_int <= 1'b0;
    cy(3);
    check({31'h0, tx_pin}, 32'h1);
    rd(SBAT_OFS_IRQ_STATUS, 32'h2, 2, 2);
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0080);
    rd(SBAT_OFS_CTRL, 32'h20, 32'h20, 32'h20);
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0000);
    rd(SBAT_OFS_CTRL, 32'h20, 0, 0);
    cy(2);
    check({31'h0, tx_pin}, 32'h0);
    tx_int <= 1'b1;
    $display("test arb_lost finished");
    // arbitration won at count 0x08, then transmit drops with no low seen
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0090);
    tx_int <= 1'b0;
    cy(4);
    tx_int <= 1'b1;
    cy(100);
    rd(SBAT_OFS_CTRL, 32'hE4, 32'h84, 32'h84);
    check({31'h0, tx_pin}, 32'h1);
    tx_int <= 1'b0;
    cy(10);
    rd(SBAT_OFS_CTRL, 32'h05, 0, 0);
    rd(SBAT_OFS_COUNT_LOW, 32'hFF, 0, 0);
    tx_int <= 1'b1;
    cy(20);
    rd(SBAT_OFS_CTRL, 32'h04, 32'h04, 32'h04);
    $display("test arb_won finished");
    // wrap past 511 leaves overflow sticky until a control write
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0040);
    pull <= 1'b1;
    cy(8);
    pull <= 1'b0;
    cy(2100);
    rd(SBAT_OFS_CTRL, 32'h0E, 32'h06, 32'h06);
    rd(SBAT_OFS_IRQ_STATUS, 32'h4, 4, 4);
    apb(1'b1, SBAT_OFS_CTRL, 32'h0000_0040);
    rd(SBAT_OFS_CTRL, 32'h0F, 0, 0);
    $display("test overflow finished");
    // idle and reserved modes both hold the count at zero
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, SBAT_OFS_CTRL, k ? 32'h0000_00C0 : 32'h0000_0000);
      repeat (3) begin
        pull <= 1'b1;
        cy(8);
        pull <= 1'b0;
        cy(8);
      end
      rd(SBAT_OFS_COUNT_LOW, 32'hFF, 0, 0);
      rd(SBAT_OFS_CTRL, 32'hC7, k ? 32'hC0 : 0, k ? 32'hC0 : 0);
    end
    $display("test idle finished");
    cy(4);
    stop_test();
  end
endmodule
`default_nettype wire
